//--- abort_irq_entry.sv
// Exception entry for precise and pended data aborts and both interrupt levels
//
// Summary of operation
// - Abort entry: link gets address plus 8, abort mode, T clear, I and A set
// - Abort vector 0x10 or high 0xFFFF0010; endian bit from configuration
// - Precise abort taken at once, before any later instruction or exception
// - An aborted store never writes memory
// - Aborting instruction's program counter load affects neither vector nor link
// - Without write-back request the base register keeps its value
// - Base-restored model: aborted write-back leaves the base unchanged
// - Same abort model for every instruction
// - Single-register aborted load leaves its destination unchanged
// - Multi-register and coprocessor aborted loads may leave anything
// - Status bits not updated on entry keep their values
// - Imprecise abort held pending while mask bit 8 set, taken once clear
// - Imprecise mask set on reset and on abort and interrupt entry
// - Mask bits writable only outside user mode
// - Normal interrupt sampled at instruction boundaries while bit 7 clear
// - Normal interrupt entry: mode 0x12, masks, fixed or controller vector
// - Interrupt link gets next instruction address plus 4
// - Fast interrupt ranks above normal and masks it on entry
// - Fast interrupt sampled at instruction boundaries while bit 6 clear
// - Fast interrupt entry: mode 0x11, all three masks set, endian bit loaded
// - Fast vector 0x1C or high 0xFFFF001C when vector enable clear
// - Order: reset, abort, fast, normal, imprecise, then the rest
// - Vector enable cleared by reset
// - Control bit 13 selects high vectors
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "exc_entry_defines.svh"
module abort_irq_entry
  import exc_entry_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Core pipeline
  input  wire logic        BOUNDARY,
  input  wire logic [31:0] ABORT_ADDR,
  input  wire logic [31:0] NEXT_ADDR,
  input  wire logic        ST_REQ,
  input  wire logic        LD_WB_REQ,
  input  wire logic        BASE_WB_REQ,
  input  wire logic        PC_LD_REQ,
  // Memory system and interrupt sources
  input  wire logic        DABORT,
  input  wire logic        IMP_ABORT,
  input  wire logic        IRQ,
  input  wire logic        FIQ,
  input  wire logic [31:0] VIC_ADDR,
  // Entry results
  output logic             EXC_TAKEN,
  output logic      [31:0] EXC_PC,
  output logic      [31:0] CUR_STATUS,
  output logic             MEM_WR_EN,
  output logic             LD_WB_EN,
  output logic             BASE_WB_EN,
  output logic             PC_LD_EN
);
  entry_state_t st_r;
  entry_state_t st_nxt;
  exc_kind_t    kind;
  logic [31:0]  vec;
  logic         ap_valid;
  logic         user_mode;
  logic [31:0]  wstatus;
  logic [31:0]  entry_status;

  exc_sel_if sel ();

  assign sel.dabort   = DABORT;
  assign sel.fiq      = FIQ;
  assign sel.irq      = IRQ;
  assign sel.imp_pend = st_r.imp_pend;
  assign sel.boundary = BOUNDARY;
  assign sel.f_mask   = st_r.cur_status[`ST_F_BIT];
  assign sel.i_mask   = st_r.cur_status[`ST_I_BIT];
  assign sel.a_mask   = st_r.cur_status[`ST_A_BIT];
  assign kind         = sel.kind;

  exc_prio u_prio (
    .sel (sel.arb)
  );

  // Vector computed from the pre-entry control bits and VIC_ADDR only, never from a loaded value
  vec_addr #(
    .AW (32)
  ) u_vec (
    .kind     (kind),
    .hivec    (st_r.hivec),
    .vec_en   (st_r.vector_enable),
    .vic_addr (VIC_ADDR),
    .addr     (vec)
  );

  assign ap_valid  = HSEL && HTRANS[1] && HREADY;
  assign user_mode = st_r.cur_status[`ST_MODE_HI:`ST_MODE_LO] == `MODE_USR;

  always_comb begin
    st_nxt = st_r;
    // Software write to the status word; masks locked in user mode
    wstatus = HWDATA;
    if (user_mode) begin
      wstatus[`ST_A_BIT:`ST_F_BIT] = st_r.cur_status[`ST_A_BIT:`ST_F_BIT];
    end
    // Common entry image: untouched bits carry over
    entry_status                               = st_r.cur_status;
    entry_status[`ST_T_BIT]                    = 1'b0;
    entry_status[`ST_I_BIT]                    = 1'b1;
    entry_status[`ST_A_BIT]                    = 1'b1;
    entry_status[`ST_E_BIT]                    = st_r.exception_endian_config;

    // Register bus: data phase write, address phase read
    st_nxt.hreadyout = 1'b1;
    st_nxt.dp_valid  = ap_valid;
    st_nxt.dp_write  = HWRITE;
    st_nxt.dp_addr   = HADDR[7:0];
    if (st_r.dp_valid && st_r.dp_write) begin
      case (st_r.dp_addr)
        `OFS_CTRL: begin
          st_nxt.vector_enable           = HWDATA[`CTRL_VECEN_BIT];
          st_nxt.hivec                   = HWDATA[`CTRL_HIVEC_BIT];
          st_nxt.exception_endian_config = HWDATA[`CTRL_EE_BIT];
        end
        `OFS_STATUS: st_nxt.cur_status = wstatus;
        default: ;
      endcase
    end
    st_nxt.hrdata = 32'h00000000;
    if (ap_valid && !HWRITE) begin
      case (HADDR[7:0])
        `OFS_CTRL: begin
          st_nxt.hrdata[`CTRL_VECEN_BIT] = st_r.vector_enable;
          st_nxt.hrdata[`CTRL_HIVEC_BIT] = st_r.hivec;
          st_nxt.hrdata[`CTRL_EE_BIT]    = st_r.exception_endian_config;
        end
        `OFS_STATUS:    st_nxt.hrdata = st_r.cur_status;
        `OFS_SAVED_ABT: st_nxt.hrdata = st_r.saved_abt;
        `OFS_SAVED_IRQ: st_nxt.hrdata = st_r.saved_irq;
        `OFS_SAVED_FIQ: st_nxt.hrdata = st_r.saved_fiq;
        `OFS_LINK_ABT:  st_nxt.hrdata = st_r.link_abt;
        `OFS_LINK_IRQ:  st_nxt.hrdata = st_r.link_irq;
        `OFS_LINK_FIQ:  st_nxt.hrdata = st_r.link_fiq;
        `OFS_PC:        st_nxt.hrdata = st_r.pc;
        `OFS_PEND:      st_nxt.hrdata[0] = st_r.imp_pend;
        default:        st_nxt.hrdata = 32'h00000000;
      endcase
    end

    // Pending imprecise abort; a new one wins over the clear on entry
    st_nxt.imp_pend = (st_r.imp_pend && kind != EXC_IMP) || IMP_ABORT;

    // Write-back gating: the aborting instruction commits nothing
    st_nxt.mem_wr_en  = ST_REQ && !DABORT;
    st_nxt.ld_wb_en   = LD_WB_REQ && !DABORT;
    st_nxt.base_wb_en = BASE_WB_REQ && !DABORT;
    st_nxt.pc_ld_en   = PC_LD_REQ && !DABORT;

    // Entry: every architectural update lands in the same edge
    st_nxt.taken = kind != EXC_NONE;
    case (kind)
      EXC_DABT, EXC_IMP: begin
        st_nxt.saved_abt = st_r.cur_status;
        st_nxt.link_abt  = (kind == EXC_DABT) ? ABORT_ADDR + `LINK_ABT_ADD
                                              : NEXT_ADDR + `LINK_ABT_ADD;
        st_nxt.cur_status = entry_status;
        st_nxt.cur_status[`ST_MODE_HI:`ST_MODE_LO] = `MODE_ABT;
        st_nxt.pc = vec;
      end
      EXC_IRQ: begin
        st_nxt.saved_irq  = st_r.cur_status;
        st_nxt.link_irq   = NEXT_ADDR + `LINK_INT_ADD;
        st_nxt.cur_status = entry_status;
        st_nxt.cur_status[`ST_MODE_HI:`ST_MODE_LO] = `MODE_IRQ;
        st_nxt.pc = vec;
      end
      EXC_FIQ: begin
        st_nxt.saved_fiq  = st_r.cur_status;
        st_nxt.link_fiq   = NEXT_ADDR + `LINK_INT_ADD;
        st_nxt.cur_status = entry_status;
        st_nxt.cur_status[`ST_F_BIT] = 1'b1;
        st_nxt.cur_status[`ST_MODE_HI:`ST_MODE_LO] = `MODE_FIQ;
        st_nxt.pc = vec;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r                         <= '0;
      st_r.cur_status              <= `STATUS_RST;
      st_r.vector_enable           <= `FLAG_RST;
      st_r.hivec                   <= `FLAG_RST;
      st_r.exception_endian_config <= `FLAG_RST;
      st_r.hreadyout               <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HRDATA     = st_r.hrdata;
  assign HREADYOUT  = st_r.hreadyout;
  assign HRESP      = st_r.taken & 1'b0;
  assign EXC_TAKEN  = st_r.taken;
  assign EXC_PC     = st_r.pc;
  assign CUR_STATUS = st_r.cur_status;
  assign MEM_WR_EN  = st_r.mem_wr_en;
  assign LD_WB_EN   = st_r.ld_wb_en;
  assign BASE_WB_EN = st_r.base_wb_en;
  assign PC_LD_EN   = st_r.pc_ld_en;

  // Checks on entry behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence s_abort_in;
    DABORT;
  endsequence

  sequence s_irq_only;
    BOUNDARY && IRQ && !st_r.cur_status[`ST_I_BIT] && !DABORT
      && !(FIQ && !st_r.cur_status[`ST_F_BIT]);
  endsequence

  sequence s_both_int;
    BOUNDARY && IRQ && FIQ && !DABORT
      && !st_r.cur_status[`ST_F_BIT] && !st_r.cur_status[`ST_I_BIT];
  endsequence

  sequence s_fiq_in;
    BOUNDARY && FIQ && !st_r.cur_status[`ST_F_BIT] && !DABORT;
  endsequence

  sequence s_imp_only;
    BOUNDARY && st_r.imp_pend && !st_r.cur_status[`ST_A_BIT] && !DABORT
      && !(FIQ && !st_r.cur_status[`ST_F_BIT]) && !(IRQ && !st_r.cur_status[`ST_I_BIT]);
  endsequence

  a_abort_state: assert property (s_abort_in |=>
    EXC_TAKEN && CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_ABT
    && st_r.link_abt == $past(ABORT_ADDR) + `LINK_ABT_ADD
    && !CUR_STATUS[`ST_T_BIT] && CUR_STATUS[`ST_I_BIT] && CUR_STATUS[`ST_A_BIT]
    && CUR_STATUS[`ST_F_BIT] == $past(st_r.cur_status[`ST_F_BIT])
    && st_r.saved_abt == $past(st_r.cur_status))
    else $error("abort entry state wrong");

  a_abort_vector: assert property (s_abort_in |=>
    EXC_PC == ($past(st_r.hivec) ? (`VEC_HIGH | `VOFF_DABT) : `VOFF_DABT)
    && CUR_STATUS[`ST_E_BIT] == $past(st_r.exception_endian_config))
    else $error("abort vector wrong");

  a_store_kill: assert property (s_abort_in |=> !MEM_WR_EN)
    else $error("aborted store reached memory");

  a_regs_kept: assert property (s_abort_in |=>
    !BASE_WB_EN && !LD_WB_EN && !PC_LD_EN)
    else $error("aborted instruction wrote a register");

  a_imp_held: assert property (
    st_r.imp_pend && st_r.cur_status[`ST_A_BIT] |=> st_r.imp_pend)
    else $error("pending imprecise abort lost while masked");

  a_user_masks: assert property (
    st_r.dp_valid && st_r.dp_write && st_r.dp_addr == `OFS_STATUS && user_mode
      && kind == EXC_NONE
    |=> CUR_STATUS[`ST_A_BIT:`ST_F_BIT] == $past(st_r.cur_status[`ST_A_BIT:`ST_F_BIT]))
    else $error("user mode changed a mask bit");

  a_irq_masked: assert property (
    IRQ && st_r.cur_status[`ST_I_BIT] && !DABORT && !FIQ && !st_r.imp_pend
    |=> !EXC_TAKEN)
    else $error("masked normal interrupt taken");

  a_irq_entry: assert property (s_irq_only |=>
    CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_IRQ
    && st_r.link_irq == $past(NEXT_ADDR) + `LINK_INT_ADD
    && EXC_PC == ($past(st_r.vector_enable) ? $past(VIC_ADDR)
                  : ($past(st_r.hivec) ? (`VEC_HIGH | `VOFF_IRQ) : `VOFF_IRQ)))
    else $error("normal interrupt entry wrong");

  a_fiq_wins: assert property (s_both_int |=>
    CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_FIQ
    && CUR_STATUS[`ST_I_BIT] && CUR_STATUS[`ST_F_BIT] && CUR_STATUS[`ST_A_BIT])
    else $error("fast interrupt did not win or mask");

  a_fiq_vector: assert property ((s_both_int and !st_r.vector_enable) |=>
    EXC_PC == ($past(st_r.hivec) ? (`VEC_HIGH | `VOFF_FIQ) : `VOFF_FIQ))
    else $error("fast interrupt vector wrong");

  a_abort_first: assert property (DABORT && BOUNDARY && FIQ |=>
    CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_ABT)
    else $error("abort did not take priority");

  a_fiq_entry: assert property (s_fiq_in |=>
    EXC_TAKEN && CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_FIQ
    && !CUR_STATUS[`ST_T_BIT] && CUR_STATUS[`ST_A_BIT:`ST_F_BIT] == 3'h7
    && CUR_STATUS[`ST_E_BIT] == $past(st_r.exception_endian_config)
    && st_r.saved_fiq == $past(st_r.cur_status)
    && st_r.link_fiq == $past(NEXT_ADDR) + `LINK_INT_ADD)
    else $error("fast interrupt entry wrong");

  a_irq_status: assert property (s_irq_only |=>
    st_r.saved_irq == $past(st_r.cur_status) && !CUR_STATUS[`ST_T_BIT]
    && CUR_STATUS[`ST_I_BIT] && CUR_STATUS[`ST_A_BIT]
    && CUR_STATUS[`ST_F_BIT] == $past(st_r.cur_status[`ST_F_BIT])
    && CUR_STATUS[`ST_E_BIT] == $past(st_r.exception_endian_config))
    else $error("normal interrupt status wrong");

  a_status_keep: assert property (kind != EXC_NONE |=>
    CUR_STATUS[31:10] == $past(st_r.cur_status[31:10]))
    else $error("entry changed an untouched status bit");

  a_imp_entry: assert property (s_imp_only |=>
    EXC_TAKEN && CUR_STATUS[`ST_MODE_HI:`ST_MODE_LO] == `MODE_ABT
    && EXC_PC == ($past(st_r.hivec) ? (`VEC_HIGH | `VOFF_DABT) : `VOFF_DABT))
    else $error("unmasked pending abort not taken");

  a_pend_set: assert property (IMP_ABORT |=> st_r.imp_pend)
    else $error("imprecise abort not pended");

  a_vec_en_kept: assert property (
    !(st_r.dp_valid && st_r.dp_write && st_r.dp_addr == `OFS_CTRL)
    |=> st_r.vector_enable == $past(st_r.vector_enable))
    else $error("vector enable changed without a control write");

  a_ctl_vector: assert property ((s_fiq_in and st_r.vector_enable) |=>
    EXC_PC == $past(VIC_ADDR))
    else $error("controller vector not used");
endmodule : abort_irq_entry

//--- exc_entry_defines.svh
// Register offsets, field positions, reset values and vector constants for exception entry
`ifndef EXC_ENTRY_DEFINES_SVH
`define EXC_ENTRY_DEFINES_SVH
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_SAVED_ABT  8'h08
`define OFS_SAVED_IRQ  8'h0C
`define OFS_SAVED_FIQ  8'h10
`define OFS_LINK_ABT   8'h14
`define OFS_LINK_IRQ   8'h18
`define OFS_LINK_FIQ   8'h1C
`define OFS_PC         8'h20
`define OFS_PEND       8'h24
`define CTRL_VECEN_BIT 0
`define CTRL_HIVEC_BIT 13
`define CTRL_EE_BIT    25
`define ST_MODE_HI     4
`define ST_MODE_LO     0
`define ST_T_BIT       5
`define ST_F_BIT       6
`define ST_I_BIT       7
`define ST_A_BIT       8
`define ST_E_BIT       9
`define MODE_USR       5'h10
`define MODE_ABT       5'h17
`define MODE_IRQ       5'h12
`define MODE_FIQ       5'h11
`define STATUS_RST     32'h000001D3
`define FLAG_RST       1'h0
`define VEC_LOW        32'h00000000
`define VEC_HIGH       32'hFFFF0000
`define VOFF_DABT      32'h00000010
`define VOFF_IRQ       32'h00000018
`define VOFF_FIQ       32'h0000001C
`define LINK_ABT_ADD   32'h00000008
`define LINK_INT_ADD   32'h00000004
`endif

//--- exc_entry_pkg.sv
// Types shared by the exception entry modules
package exc_entry_pkg;
  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_DABT = 3'b001,
    EXC_FIQ  = 3'b010,
    EXC_IRQ  = 3'b011,
    EXC_IMP  = 3'b100
  } exc_kind_t;

  typedef struct packed {
    logic [31:0] cur_status;
    logic [31:0] saved_abt;
    logic [31:0] saved_irq;
    logic [31:0] saved_fiq;
    logic [31:0] link_abt;
    logic [31:0] link_irq;
    logic [31:0] link_fiq;
    logic [31:0] pc;
    logic        vector_enable;
    logic        hivec;
    logic        exception_endian_config;
    logic        imp_pend;
    logic        taken;
    logic        mem_wr_en;
    logic        ld_wb_en;
    logic        base_wb_en;
    logic        pc_ld_en;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
  } entry_state_t;
endpackage : exc_entry_pkg

//--- exc_sel_if.sv
// Request and grant bundle between the entry logic and its arbiter
`timescale 1ns/1ps
interface exc_sel_if;
  import exc_entry_pkg::*;
  logic      dabort;
  logic      fiq;
  logic      irq;
  logic      imp_pend;
  logic      boundary;
  logic      f_mask;
  logic      i_mask;
  logic      a_mask;
  exc_kind_t kind;
  modport ctl (output dabort, fiq, irq, imp_pend, boundary, f_mask, i_mask, a_mask,
               input kind);
  modport arb (input dabort, fiq, irq, imp_pend, boundary, f_mask, i_mask, a_mask,
               output kind);
endinterface : exc_sel_if

//--- exc_prio.sv
// Fixed priority choice among pending exceptions
`timescale 1ns/1ps
module exc_prio
  import exc_entry_pkg::*;
(
  // Requests and grant
  exc_sel_if.arb sel
);
  always_comb begin
    if (sel.dabort) begin
      sel.kind = EXC_DABT;
    end else if (sel.boundary && sel.fiq && !sel.f_mask) begin
      sel.kind = EXC_FIQ;
    end else if (sel.boundary && sel.irq && !sel.i_mask) begin
      sel.kind = EXC_IRQ;
    end else if (sel.boundary && sel.imp_pend && !sel.a_mask) begin
      sel.kind = EXC_IMP;
    end else begin
      sel.kind = EXC_NONE;
    end
  end
endmodule : exc_prio

//--- vec_addr.sv
// Handler address for the chosen exception
`timescale 1ns/1ps
`include "exc_entry_defines.svh"
module vec_addr
  import exc_entry_pkg::*;
#(
  parameter int AW = 32
)(
  // Selection
  input  wire exc_kind_t     kind,
  input  wire logic          hivec,
  input  wire logic          vec_en,
  input  wire logic [AW-1:0] vic_addr,
  // Result
  output logic      [AW-1:0] addr
);
  logic [AW-1:0] base;

  always_comb begin
    base = hivec ? AW'(`VEC_HIGH) : AW'(`VEC_LOW);
    case (kind)
      EXC_DABT, EXC_IMP: addr = base | AW'(`VOFF_DABT);
      EXC_IRQ:  addr = vec_en ? vic_addr : (base | AW'(`VOFF_IRQ));
      EXC_FIQ:  addr = vec_en ? vic_addr : (base | AW'(`VOFF_FIQ));
      default:  addr = base;
    endcase
  end
endmodule : vec_addr

//--- exc_src_model.sv
// Abort and interrupt source model facing the entry block
`timescale 1ns/1ps
`include "exc_entry_defines.svh"
module exc_src_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Bench commands: bit0 abort, bit1 imprecise, bit2 normal, bit3 fast
  input  wire logic [3:0]  go,
  input  wire logic [31:0] vec,
  // Entry feedback
  input  wire logic        taken,
  input  wire logic [4:0]  mode,
  // Requests to the block
  output logic             dabort,
  output logic             imp_abort,
  output logic             irq,
  output logic             fiq,
  output logic      [31:0] vic_addr
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {dabort, imp_abort, irq, fiq} <= 4'h0;
      vic_addr <= 32'h0;
    end else begin
      dabort    <= go[0];
      imp_abort <= go[1];
      // Held until serviced, since a masked request must not be lost
      irq <= go[2] | (irq & !(taken && mode == `MODE_IRQ));
      fiq <= go[3] | (fiq & !(taken && mode == `MODE_FIQ));
      if (go[2]) begin
        vic_addr <= vec;
      end
    end
  end
endmodule : exc_src_model

//--- abort_irq_entry_test.sv
// Self-checking bench for the abort and interrupt entry block
`timescale 1ns/1ps
`include "exc_entry_defines.svh"
module abort_irq_entry_test;
  logic        CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, BOUNDARY, EXC_TAKEN;
  logic        ST_REQ, LD_WB_REQ, BASE_WB_REQ, PC_LD_REQ, DABORT, IMP_ABORT, IRQ, FIQ;
  logic        MEM_WR_EN, LD_WB_EN, BASE_WB_EN, PC_LD_EN;
  logic [31:0] HADDR, HWDATA, HRDATA, ABORT_ADDR, NEXT_ADDR, VIC_ADDR, EXC_PC, CUR_STATUS;
  logic [31:0] vec;
  logic [3:0]  go;
  logic [2:0]  HSIZE;
  logic [1:0]  HTRANS;
  int          err_count, tests_run;

  abort_irq_entry abort_irq_entry_i (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BOUNDARY(BOUNDARY),
    .ABORT_ADDR(ABORT_ADDR), .NEXT_ADDR(NEXT_ADDR), .ST_REQ(ST_REQ), .LD_WB_REQ(LD_WB_REQ),
    .BASE_WB_REQ(BASE_WB_REQ), .PC_LD_REQ(PC_LD_REQ), .DABORT(DABORT), .IMP_ABORT(IMP_ABORT),
    .IRQ(IRQ), .FIQ(FIQ), .VIC_ADDR(VIC_ADDR), .EXC_TAKEN(EXC_TAKEN), .EXC_PC(EXC_PC),
    .CUR_STATUS(CUR_STATUS), .MEM_WR_EN(MEM_WR_EN), .LD_WB_EN(LD_WB_EN),
    .BASE_WB_EN(BASE_WB_EN), .PC_LD_EN(PC_LD_EN));

  exc_src_model exc_src_model_i (.clk(CLK), .rstn(RSTN), .go(go), .vec(vec),
    .taken(EXC_TAKEN), .mode(CUR_STATUS[4:0]), .dabort(DABORT), .imp_abort(IMP_ABORT),
    .irq(IRQ), .fiq(FIQ), .vic_addr(VIC_ADDR));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Status after entry: mode, T clear, I and A set, F set or kept, endian loaded
  function automatic logic [31:0] ent(input logic [31:0] s, input logic [4:0] m,
                                      input logic f, input logic e);
    ent = {s[31:10], e, 1'b1, 1'b1, f | s[6], 1'b0, m};
  endfunction : ent

  task rdy;
    int n;
    n = 0;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        summarize();
      end
      @(posedge CLK);
    end
  endtask : rdy

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= wr;
    rdy();
    HTRANS <= 2'h0;
    HSEL   <= 1'b0;
    HWDATA <= wd;
    rdy();
    rd = HRDATA;
    chk({31'h0, HRESP}, 32'h0);
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    @(posedge CLK);
    ahb(1'b1, a, d, v);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    @(posedge CLK);
    ahb(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask : rdc

  // Bounded wait; a missing entry that was due ends the run
  task wait_entry(input int n, input logic want);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n && !hit; k++) begin
      @(posedge CLK);
      // Sampled at the edge, before it launches anything new
      hit = (EXC_TAKEN === 1'b1);
    end
    chk({31'h0, hit}, {31'h0, want});
    if (want && !hit) begin
      summarize();
    end
  endtask : wait_entry

  initial begin
    logic [31:0] st, a, v;
    logic        hv, ee;
    {HSEL, HWRITE, BOUNDARY, ST_REQ, LD_WB_REQ, BASE_WB_REQ, PC_LD_REQ} = 7'h0;
    {HADDR, HWDATA, ABORT_ADDR, NEXT_ADDR, vec} = 160'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    go = 4'h0;
    RSTN = 1'b0;
    err_count = 0;
    tests_run = 0;
    st = $urandom(79);
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    rdc(`OFS_STATUS, `STATUS_RST);
    rdc(`OFS_CTRL, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    $display("test reset done");
    // Precise aborts over vector range and endian setting; fast request races one
    for (int i = 0; i < 4; i++) begin
      hv = i[0];
      ee = i[1];
      wr(`OFS_CTRL, {6'h0, ee, 11'h0, hv, 13'h0});
      st = ($urandom() & 32'hFFFFFC00) | 32'h00000013 | (hv ? 32'h40 : 32'h0);
      wr(`OFS_STATUS, st);
      a = $urandom() & 32'hFFFFFFFC;
      ABORT_ADDR <= a;
      {ST_REQ, LD_WB_REQ, BASE_WB_REQ, PC_LD_REQ} <= 4'hF;
      repeat (2) @(posedge CLK);
      chk({28'h0, MEM_WR_EN, LD_WB_EN, BASE_WB_EN, PC_LD_EN}, 32'hF);
      go <= (i == 2) ? 4'h9 : 4'h1;
      BOUNDARY <= (i == 2);
      @(posedge CLK);
      go <= 4'h0;
      wait_entry(6, 1'b1);
      chk(EXC_PC, hv ? 32'hFFFF0010 : 32'h10);
      chk(CUR_STATUS, ent(st, `MODE_ABT, 1'b0, ee));
      chk({28'h0, MEM_WR_EN, LD_WB_EN, BASE_WB_EN, PC_LD_EN}, 32'h0);
      if (i == 2) begin
        wait_entry(4, 1'b1);
        chk(CUR_STATUS, ent(ent(st, `MODE_ABT, 1'b0, ee), `MODE_FIQ, 1'b1, ee));
        chk(EXC_PC, 32'h1C);
      end
      BOUNDARY <= 1'b0;
      {ST_REQ, LD_WB_REQ, BASE_WB_REQ, PC_LD_REQ} <= 4'h0;
      rdc(`OFS_LINK_ABT, a + 32'h8);
      rdc(`OFS_SAVED_ABT, st);
    end
    $display("test precise abort done");
    // Imprecise abort pends while masked, taken once the mask clears
    BOUNDARY <= 1'b1;
    go <= 4'h2;
    @(posedge CLK);
    go <= 4'h0;
    wait_entry(4, 1'b0);
    rdc(`OFS_PEND, 32'h1);
    wr(`OFS_STATUS, 32'h000000D3);
    wait_entry(4, 1'b1);
    chk(EXC_PC, 32'hFFFF0010);
    chk(CUR_STATUS, ent(32'h000000D3, `MODE_ABT, 1'b0, 1'b1));
    BOUNDARY <= 1'b0;
    rdc(`OFS_PEND, 32'h0);
    $display("test imprecise abort done");
    // Interrupts: fixed, controller and high vectors; fast beats normal
    for (int j = 0; j < 3; j++) begin
      hv = (j == 2);
      wr(`OFS_CTRL, {18'h0, hv, 12'h0, j == 1});
      st = ($urandom() & 32'hFFFFFC00) | 32'h00000013;
      wr(`OFS_STATUS, st);
      a = $urandom() & 32'hFFFFFFFC;
      v = $urandom();
      NEXT_ADDR <= a;
      vec <= v;
      go <= (j >= 1) ? 4'hC : 4'h4;
      @(posedge CLK);
      go <= 4'h0;
      wait_entry(4, 1'b0);
      BOUNDARY <= 1'b1;
      wait_entry(4, 1'b1);
      BOUNDARY <= 1'b0;
      if (j >= 1) begin
        chk(EXC_PC, (j == 1) ? v : 32'hFFFF001C);
        chk(CUR_STATUS, ent(st, `MODE_FIQ, 1'b1, 1'b0));
        rdc(`OFS_LINK_FIQ, a + 32'h4);
        rdc(`OFS_SAVED_FIQ, st);
        wr(`OFS_STATUS, st);
        BOUNDARY <= 1'b1;
        wait_entry(4, 1'b1);
        BOUNDARY <= 1'b0;
      end
      chk(EXC_PC, (j == 1) ? v : (hv ? 32'hFFFF0018 : 32'h18));
      chk(CUR_STATUS, ent(st, `MODE_IRQ, 1'b0, 1'b0));
      rdc(`OFS_LINK_IRQ, a + 32'h4);
      rdc(`OFS_SAVED_IRQ, st);
    end
    wr(`OFS_SAVED_IRQ, ~st);
    rdc(`OFS_SAVED_IRQ, st);
    $display("test interrupts done");
    // Masks frozen in user mode; a masked request stays untaken
    wr(`OFS_STATUS, 32'h00000010);
    wr(`OFS_STATUS, 32'h000001D0);
    rdc(`OFS_STATUS, 32'h00000010);
    wr(`OFS_STATUS, 32'h000001D3);
    rdc(`OFS_STATUS, 32'h00000013);
    wr(`OFS_STATUS, 32'h000001D3);
    rdc(`OFS_STATUS, 32'h000001D3);
    BOUNDARY <= 1'b1;
    go <= 4'hC;
    @(posedge CLK);
    go <= 4'h0;
    wait_entry(5, 1'b0);
    $display("test masks done");
    summarize();
  end
endmodule : abort_irq_entry_test
